// ---- src/mw_top.sv ----
// monitor wrapper: avalon slave, area decode, split or wait answers, start select
//
// Overview of operation
// - split option set: access while primitive busy gets a split answer.
// - split option clear: waitrequest held high until primitive operation finishes.
// - external start option zero: conversion start driven from control register bit.
// - external start option nonzero: conversion start input passed straight through.
// - word alignment: primitive register n sits at offset n times four.
// - no word alignment: primitive register n sits at offset n times two.
// - primitive registers 0x40..0x4a load build-time values; 0x42 defaults 0x0800.
// - two decoded areas, config and primitive, each with address and mask.
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "mw_defines.svh"
module mw_top
  import mw_pkg::*;
#(
  parameter bit          SPLIT      = 1'b0,
  parameter bit          EXT_CONV   = 1'b0,
  parameter bit          WORD_ALIGN = 1'b0,
  parameter logic [11:0] CADDR      = `MW_CADDR_DEF,
  parameter logic [11:0] CMASK      = `MW_CMASK_DEF,
  parameter logic [11:0] SADDR      = `MW_SADDR_DEF,
  parameter logic [11:0] SMASK      = `MW_SMASK_DEF,
  parameter logic [15:0] INIT_40    = `MW_INIT_DEF,
  parameter logic [15:0] INIT_41    = `MW_INIT_DEF,
  parameter logic [15:0] INIT_42    = `MW_INIT_42_DEF,
  parameter logic [15:0] INIT_43    = `MW_INIT_DEF,
  parameter logic [15:0] INIT_44    = `MW_INIT_DEF,
  parameter logic [15:0] INIT_45    = `MW_INIT_DEF,
  parameter logic [15:0] INIT_46    = `MW_INIT_DEF,
  parameter logic [15:0] INIT_47    = `MW_INIT_DEF,
  parameter logic [15:0] INIT_48    = `MW_INIT_DEF,
  parameter logic [15:0] INIT_49    = `MW_INIT_DEF,
  parameter logic [15:0] init_value_reg_4a = `MW_INIT_DEF
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic      [1:0]  avs_response,
  output logic             avs_waitrequest,
  input  wire logic        conversion_start_in,
  output logic             split_complete,
  output logic             conversion_start
);
  // init values gathered for the primitive
  localparam mw_init_t INIT = {init_value_reg_4a, INIT_49, INIT_48, INIT_47, INIT_46,
                               INIT_45, INIT_44, INIT_43, INIT_42, INIT_41, INIT_40};

  mw_prim_if  pif ();
  mw_bus_st_t st_r, st_nxt;
  mw_op_st_t  op_r, op_nxt;
  logic        ctrl_conv_r, ctrl_conv_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  resp_r, resp_nxt;
  logic [15:0] held_r, held_nxt;
  logic [6:0]  hold_idx_r, hold_idx_nxt;
  logic        hold_we_r, hold_we_nxt;
  logic        lane_r, lane_nxt;
  logic        split_cmp_r, split_cmp_nxt;
  logic        prim_eoc, prim_busy;
  logic        req, cfg_hit, mon_hit, lane;
  logic [6:0]  idx;

  // ***************************************************
  // decode helpers
  // ***************************************************
  // area match on address and mask
  function automatic logic area_hit(input logic [11:0] a, input logic [11:0] base,
                                    input logic [11:0] mask);
    return ((a ^ base) & mask) == 12'h000;
  endfunction

  // place a 16-bit value on its byte lanes
  function automatic logic [31:0] lane_put(input logic upper, input logic [15:0] d);
    return upper ? {d, 16'h0000} : {16'h0000, d};
  endfunction

  assign req     = avs_read | avs_write;
  assign cfg_hit = area_hit(avs_address[31:20], CADDR, CMASK);
  assign mon_hit = !cfg_hit && area_hit(avs_address[31:20], SADDR, SMASK);
  assign idx     = WORD_ALIGN ? avs_address[8:2] : avs_address[7:1];
  assign lane    = WORD_ALIGN ? 1'b0 : avs_address[1];

  // ***************************************************
  // primitive port
  // ***************************************************
  // start a primitive access from idle on a monitor-area request
  always_comb begin
    pif.req   = 1'b0;
    pif.we    = avs_write;
    pif.addr  = idx;
    pif.wdata = lane ? avs_writedata[31:16] : avs_writedata[15:0];
    if (st_r == ST_IDLE && req && mon_hit) begin
      if (!SPLIT)
        pif.req = 1'b1;
      else if (op_r == OP_NONE)
        pif.req = 1'b1;
      else if (op_r == OP_HELD && !(idx == hold_idx_r && avs_write == hold_we_r))
        pif.req = 1'b1;
    end
  end

  mw_prim #(
    .INIT (INIT)
  ) u_prim (
    .ref_clk          (ref_clk),
    .rst_n            (rst_n),
    .port             (pif.prim),
    .conversion_start (conversion_start),
    .eoc              (prim_eoc),
    .busy             (prim_busy)
  );

  // register bit, pass-through of the input
  assign conversion_start = EXT_CONV ? conversion_start_in : ctrl_conv_r;

  // ***************************************************
  // bus and split state
  // ***************************************************
  // next state of the bus answer and the split bookkeeping
  always_comb begin
    st_nxt        = st_r;
    op_nxt        = op_r;
    ctrl_conv_nxt = ctrl_conv_r;
    rdata_nxt     = rdata_r;
    resp_nxt      = resp_r;
    held_nxt      = held_r;
    hold_idx_nxt  = hold_idx_r;
    hold_we_nxt   = hold_we_r;
    lane_nxt      = lane_r;
    split_cmp_nxt = 1'b0;
    // split operation ends: keep result, signal completion
    if (op_r == OP_RUN && pif.ready) begin
      held_nxt      = pif.rdata;
      op_nxt        = OP_HELD;
      split_cmp_nxt = 1'b1;
    end
    unique case (st_r)
      ST_IDLE: begin
        if (req) begin
          st_nxt    = ST_RESP;
          resp_nxt  = `MW_RESP_OKAY;
          rdata_nxt = 32'h0000_0000;
          if (cfg_hit) begin
            if (avs_address[7:0] == `MW_OFS_CTRL) begin
              if (avs_write) ctrl_conv_nxt = avs_writedata[`MW_CTRL_CONV_BIT];
              rdata_nxt[`MW_CTRL_CONV_BIT] = ctrl_conv_r;
            end else if (avs_address[7:0] == `MW_OFS_STAT) begin
              rdata_nxt[`MW_STAT_WAL_BIT]  = WORD_ALIGN;
              rdata_nxt[`MW_STAT_EOC_BIT]  = prim_eoc;
              rdata_nxt[`MW_STAT_BUSY_BIT] = prim_busy;
              rdata_nxt[`MW_STAT_PEND_BIT] = (op_r == OP_RUN);
              rdata_nxt[`MW_STAT_HELD_BIT] = (op_r == OP_HELD);
            end
          end else if (mon_hit && !SPLIT) begin
            st_nxt   = ST_WAIT;
            lane_nxt = lane;
          end else if (mon_hit && op_r == OP_HELD && idx == hold_idx_r
                       && avs_write == hold_we_r) begin
            // retry after completion collects the result
            rdata_nxt = lane_put(lane, held_r);
            op_nxt    = OP_NONE;
          end else if (mon_hit) begin
            // busy or newly started: answer split
            resp_nxt = `MW_RESP_SPLIT;
            if (pif.req) begin
              op_nxt       = OP_RUN;
              hold_idx_nxt = idx;
              hold_we_nxt  = avs_write;
            end
          end else begin
            resp_nxt = `MW_RESP_DECERR;
          end
        end
      end
      ST_WAIT: begin
        if (pif.ready) begin
          rdata_nxt = lane_put(lane_r, pif.rdata);
          resp_nxt  = `MW_RESP_OKAY;
          st_nxt    = ST_RESP;
        end
      end
      ST_RESP: st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  // register the bus and split state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r        <= ST_IDLE;
      op_r        <= OP_NONE;
      ctrl_conv_r <= `MW_CTRL_RST;
      rdata_r     <= 32'h0000_0000;
      resp_r      <= `MW_RESP_OKAY;
      held_r      <= 16'h0000;
      hold_idx_r  <= 7'h00;
      hold_we_r   <= 1'b0;
      lane_r      <= 1'b0;
      split_cmp_r <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      op_r        <= op_nxt;
      ctrl_conv_r <= ctrl_conv_nxt;
      rdata_r     <= rdata_nxt;
      resp_r      <= resp_nxt;
      held_r      <= held_nxt;
      hold_idx_r  <= hold_idx_nxt;
      hold_we_r   <= hold_we_nxt;
      lane_r      <= lane_nxt;
      split_cmp_r <= split_cmp_nxt;
    end
  end

  // answer outputs
  assign avs_waitrequest = (st_r != ST_RESP);
  assign avs_readdata    = rdata_r;
  assign avs_response    = resp_r;
  assign split_complete  = split_cmp_r;
endmodule // mw_top
`default_nettype wire

// ---- common/mw_defines.svh ----
// offsets, field positions, reset values and timing counts of the monitor wrapper
`ifndef MW_DEFINES_SVH
`define MW_DEFINES_SVH

// ***************************************************
// area decode defaults (address bits 31:20)
// ***************************************************
`define MW_CADDR_DEF      12'h000
`define MW_CMASK_DEF      12'hfff
`define MW_SADDR_DEF      12'h001
`define MW_SMASK_DEF      12'hfff

// ***************************************************
// wrapper registers in the configuration area
// ***************************************************
`define MW_OFS_CTRL       8'h00
`define MW_OFS_STAT       8'h04
`define MW_CTRL_CONV_BIT  0
`define MW_STAT_WAL_BIT   31
`define MW_STAT_EOC_BIT   4
`define MW_STAT_BUSY_BIT  3
`define MW_STAT_PEND_BIT  1
`define MW_STAT_HELD_BIT  0
`define MW_CTRL_RST       1'b0

// ***************************************************
// bus answers
// ***************************************************
`define MW_RESP_OKAY      2'h0
`define MW_RESP_SPLIT     2'h1
`define MW_RESP_DECERR    2'h3

// ***************************************************
// primitive register space
// ***************************************************
`define MW_PRIM_AW        7
`define MW_PRIM_DW        16
`define MW_PRIM_DEPTH     128
`define MW_INIT_FIRST     7'h40
`define MW_INIT_COUNT     11
`define MW_INIT_DEF       16'h0000
`define MW_INIT_42_DEF    16'h0800
`define MW_RESULT_IDX     7'h00

// ***************************************************
// timing: access and conversion durations in ns at 100 MHz
// ***************************************************
`define MW_CLK_NS         10
`define MW_ACCESS_NS      40
`define MW_CONV_NS        260
`define MW_ACCESS_CYC     (`MW_ACCESS_NS / `MW_CLK_NS)
`define MW_CONV_CYC       (`MW_CONV_NS / `MW_CLK_NS)

`endif

// ---- common/mw_pkg.sv ----
// types shared by the monitor wrapper modules
package mw_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RESP} mw_bus_st_t;
  typedef enum logic [1:0] {OP_NONE, OP_RUN, OP_HELD} mw_op_st_t;
  typedef logic [10:0][15:0] mw_init_t;
endpackage

// ---- common/mw_prim_if.sv ----
// register access port between the wrapper and the monitor primitive
`timescale 1ns/1ps
`default_nettype none
interface mw_prim_if;
  logic        req;
  logic        we;
  logic [6:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ready;
  modport wrap (output req, output we, output addr, output wdata, input rdata, input ready);
  modport prim (input req, input we, input addr, input wdata, output rdata, output ready);
endinterface
`default_nettype wire

// ---- src/mw_prim.sv ----
// monitor primitive: register space, access latency and conversion engine
`timescale 1ns/1ps
`default_nettype none
`include "mw_defines.svh"
module mw_prim
  import mw_pkg::*;
#(
  parameter mw_init_t INIT = '0
) (
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  mw_prim_if.prim    port,
  input  wire logic  conversion_start,
  output logic       eoc,
  output logic       busy
);
  localparam int ACC_CYC  = (`MW_ACCESS_CYC < 1) ? 1 : `MW_ACCESS_CYC;
  localparam int CONV_CYC = (`MW_CONV_CYC < 1) ? 1 : `MW_CONV_CYC;

  logic [15:0] mem_r [`MW_PRIM_DEPTH];
  logic [15:0] mem_nxt [`MW_PRIM_DEPTH];
  logic [3:0]  acc_cnt_r, acc_cnt_nxt;
  logic        acc_we_r, acc_we_nxt;
  logic [6:0]  acc_addr_r, acc_addr_nxt;
  logic [15:0] acc_wd_r, acc_wd_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        ready_r, ready_nxt;
  logic [5:0]  conv_cnt_r, conv_cnt_nxt;
  logic        conv_prev_r, eoc_r, eoc_nxt;

  // reset value of register i
  function automatic logic [15:0] init_of(input int i);
    if (i >= int'(`MW_INIT_FIRST) && i < int'(`MW_INIT_FIRST) + `MW_INIT_COUNT)
      return INIT[i - int'(`MW_INIT_FIRST)];
    return `MW_INIT_DEF;
  endfunction

  // access sequencing and conversion
  always_comb begin
    mem_nxt      = mem_r;
    acc_cnt_nxt  = acc_cnt_r;
    acc_we_nxt   = acc_we_r;
    acc_addr_nxt = acc_addr_r;
    acc_wd_nxt   = acc_wd_r;
    rdata_nxt    = rdata_r;
    ready_nxt    = 1'b0;
    conv_cnt_nxt = conv_cnt_r;
    eoc_nxt      = eoc_r;
    if (acc_cnt_r == 4'h0) begin
      if (port.req) begin
        acc_cnt_nxt  = 4'(ACC_CYC);
        acc_we_nxt   = port.we;
        acc_addr_nxt = port.addr;
        acc_wd_nxt   = port.wdata;
      end
    end else begin
      acc_cnt_nxt = acc_cnt_r - 4'h1;
      if (acc_cnt_r == 4'h1) begin
        ready_nxt = 1'b1;
        if (acc_we_r) mem_nxt[acc_addr_r] = acc_wd_r;
        else rdata_nxt = mem_r[acc_addr_r];
      end
    end
    // rising start begins a conversion
    if (conversion_start && !conv_prev_r && conv_cnt_r == 6'h00) begin
      conv_cnt_nxt = 6'(CONV_CYC);
      eoc_nxt      = 1'b0;
    end else if (conv_cnt_r != 6'h00) begin
      conv_cnt_nxt = conv_cnt_r - 6'h01;
      if (conv_cnt_r == 6'h01) begin
        eoc_nxt = 1'b1;
        mem_nxt[`MW_RESULT_IDX] = mem_r[`MW_RESULT_IDX] + 16'h0001;
      end
    end
  end

  // storage and control flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `MW_PRIM_DEPTH; i++) begin
        mem_r[i] <= init_of(i);
      end
      acc_cnt_r   <= 4'h0;
      acc_we_r    <= 1'b0;
      acc_addr_r  <= 7'h00;
      acc_wd_r    <= 16'h0000;
      rdata_r     <= 16'h0000;
      ready_r     <= 1'b0;
      conv_cnt_r  <= 6'h00;
      conv_prev_r <= 1'b0;
      eoc_r       <= 1'b0;
    end else begin
      mem_r       <= mem_nxt;
      acc_cnt_r   <= acc_cnt_nxt;
      acc_we_r    <= acc_we_nxt;
      acc_addr_r  <= acc_addr_nxt;
      acc_wd_r    <= acc_wd_nxt;
      rdata_r     <= rdata_nxt;
      ready_r     <= ready_nxt;
      conv_cnt_r  <= conv_cnt_nxt;
      conv_prev_r <= conversion_start;
      eoc_r       <= eoc_nxt;
    end
  end

  assign port.rdata = rdata_r;
  assign port.ready = ready_r;
  assign eoc        = eoc_r;
  assign busy       = (conv_cnt_r != 6'h00) || (acc_cnt_r != 4'h0);
endmodule // mw_prim
`default_nettype wire

// ---- verification/mw_master.sv ----
// avalon bus master model standing in for the ahb master
`timescale 1ns/1ps
`default_nettype none
module mw_master (
  input  wire logic        ref_clk,
  output logic      [31:0] avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic [1:0]  avs_response,
  input  wire logic        avs_waitrequest
);
  // idle bus at time zero
  initial begin
    avs_address   = 32'h0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
  end
  // one transfer: request held until waitrequest is sampled low
  task automatic access(input logic [31:0] a, input logic we, input logic [31:0] d,
                        output logic [31:0] q, output logic [1:0] r);
    int n;
    n = 0;
    q = 32'h0;
    r = 2'h2; // marks a transfer that never ended
    @(posedge ref_clk);
    avs_address   <= a;
    avs_read      <= !we;
    avs_write     <= we;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (avs_waitrequest === 1'b0) begin
      q = avs_readdata;
      r = avs_response;
    end
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    avs_writedata <= ~d; // released data no longer shows the old value
  endtask
endmodule // mw_master
`default_nettype wire

// ---- verification/mw_top_sva.sv ----
// concurrent checks on the monitor wrapper ports
`timescale 1ns/1ps
`default_nettype none
`include "mw_defines.svh"
module mw_top_sva
  import mw_pkg::*;
#(
  parameter bit SPLIT    = 1'b0,
  parameter bit EXT_CONV = 1'b0
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [31:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic [1:0]  avs_response,
  input wire logic        avs_waitrequest,
  input wire logic        conversion_start_in,
  input wire logic        split_complete,
  input wire logic        conversion_start
);
  logic req, prim, cfg, pend_r, pend_nxt;
  // request and area decode
  assign req  = avs_read | avs_write;
  assign prim = avs_address[31:20] == `MW_SADDR_DEF;
  assign cfg  = avs_address[31:20] == `MW_CADDR_DEF;
  // split operation outstanding until its completion pulse
  always_comb begin
    pend_nxt = pend_r;
    if (split_complete)
      pend_nxt = 1'b0;
    else if (!avs_waitrequest && avs_response == `MW_RESP_SPLIT)
      pend_nxt = 1'b1;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      pend_r <= 1'b0;
    else
      pend_r <= pend_nxt;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_wait_prim: assert property (!SPLIT && $rose(req) && prim |-> avs_waitrequest[*6]
    ##1 (!avs_waitrequest && avs_response == `MW_RESP_OKAY)) else $error("wait answer timing");
  a_fast_answer: assert property ((SPLIT || !prim) && $rose(req) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("fast answer timing");
  a_split_busy: assert property (SPLIT && $rose(req) && prim && pend_r && !split_complete
    |-> ##1 avs_response == `MW_RESP_SPLIT) else $error("busy access not split");
  a_cmpl_bound: assert property (SPLIT && !avs_waitrequest && !pend_r &&
    avs_response == `MW_RESP_SPLIT |-> ##[1:12] split_complete) else $error("no completion");
  a_ext_start: assert property (EXT_CONV |-> conversion_start == conversion_start_in)
    else $error("external start not passed");
  a_ctrl_start: assert property (!EXT_CONV && avs_write && !avs_waitrequest && cfg &&
    avs_address[7:0] == `MW_OFS_CTRL |=> conversion_start == $past(avs_writedata[0]))
    else $error("start bit not applied");
  a_dec_error: assert property ($rose(req) && !prim && !cfg |-> ##1
    (!avs_waitrequest && avs_response == `MW_RESP_DECERR && avs_readdata == 32'h0))
    else $error("unmapped access answer");
  a_idle_wait: assert property (!req |-> avs_waitrequest)
    else $error("waitrequest low while idle");
  c_split: cover property (!avs_waitrequest && avs_response == `MW_RESP_SPLIT);
  c_decerr: cover property (!avs_waitrequest && avs_response == `MW_RESP_DECERR);
  c_start: cover property ($rose(conversion_start));
endmodule // mw_top_sva
bind mw_top mw_top_sva #(.SPLIT(SPLIT), .EXT_CONV(EXT_CONV)) mw_top_sva_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
  .conversion_start_in(conversion_start_in), .split_complete(split_complete),
  .conversion_start(conversion_start));
`default_nettype wire

// ---- verification/monitor_ahb_wrapper_config_test.sv ----
// bench: wait-state word-spaced instance and split half-word instance
`timescale 1ns/1ps
`default_nettype none
`include "mw_defines.svh"
module monitor_ahb_wrapper_config_test;
  import mw_pkg::*;
  logic        ref_clk, rst_n, conv_in;
  logic [31:0] a_adr, a_wd, a_rd, b_adr, b_wd, b_rd;
  logic        a_rv, a_wv, a_wt, a_sc, a_cs, b_rv, b_wv, b_wt, b_sc, b_cs;
  logic [1:0]  a_rs, b_rs;
  logic [15:0] seed;
  int          n_errors, samples_checked, b_ncmpl;
  // clock and completion counter of the split side
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (b_sc === 1'b1) b_ncmpl++;
  mw_top #(.WORD_ALIGN(1'b1)) mw_top_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(a_adr), .avs_read(a_rv),
    .avs_write(a_wv), .avs_writedata(a_wd), .avs_readdata(a_rd), .avs_response(a_rs),
    .avs_waitrequest(a_wt), .conversion_start_in(conv_in), .split_complete(a_sc),
    .conversion_start(a_cs));
  mw_top #(.SPLIT(1'b1), .EXT_CONV(1'b1), .WORD_ALIGN(1'b0)) mw_top_inst_b (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(b_adr), .avs_read(b_rv),
    .avs_write(b_wv), .avs_writedata(b_wd), .avs_readdata(b_rd), .avs_response(b_rs),
    .avs_waitrequest(b_wt), .conversion_start_in(conv_in), .split_complete(b_sc),
    .conversion_start(b_cs));
  mw_master ma (.ref_clk(ref_clk), .avs_address(a_adr), .avs_read(a_rv), .avs_write(a_wv),
    .avs_writedata(a_wd), .avs_readdata(a_rd), .avs_response(a_rs), .avs_waitrequest(a_wt));
  mw_master mb (.ref_clk(ref_clk), .avs_address(b_adr), .avs_read(b_rv), .avs_write(b_wv),
    .avs_writedata(b_wd), .avs_readdata(b_rd), .avs_response(b_rs), .avs_waitrequest(b_wt));
  // expectations and random source
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] padr(input logic [6:0] i, input bit wa);
    return {`MW_SADDR_DEF, 20'h0} | (wa ? 32'({i, 2'b00}) : 32'({i, 1'b0}));
  endfunction
  function automatic logic [15:0] init_exp(input logic [6:0] i);
    return (i == 7'h42) ? `MW_INIT_42_DEF : `MW_INIT_DEF;
  endfunction
  task automatic close_out();
    $display("counts: checked %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one access; on the split side a split answer is waited out and retried
  task automatic xfer(input bit b, input logic [31:0] a, input logic we, input logic [15:0] d,
                      output logic [15:0] q, output logic [1:0] r);
    logic [31:0] wd, rd;
    int          n0, k;
    wd = a[1] ? {d, 16'h0} : {16'h0, d};
    n0 = b_ncmpl;
    k  = 0;
    if (b)
      mb.access(a, we, wd, rd, r);
    else
      ma.access(a, we, wd, rd, r);
    if (b && a[31:20] == `MW_SADDR_DEF) begin
      check({r, 32'h0}, {`MW_RESP_SPLIT, 32'h0});
      // a second request while the operation still runs is split again
      mb.access(a, we, wd, rd, r);
      check({r, 32'h0}, {`MW_RESP_SPLIT, 32'h0});
      while (b_ncmpl == n0 && k < 60) begin
        @(posedge ref_clk);
        k++;
      end
      check(34'(b_ncmpl - n0), 34'h1);
      mb.access(a, we, wd, rd, r);
    end
    q = a[1] ? rd[31:16] : rd[15:0];
    if (k >= 60 || r === 2'h2) begin
      n_errors++;
      close_out();
    end
  endtask
  initial begin
    logic [15:0] q, d;
    logic [1:0]  r;
    logic [6:0]  ix;
    ref_clk         = 1'b0;
    rst_n           = 1'b0;
    conv_in         = 1'b0;
    seed            = 16'd11155;
    n_errors        = 0;
    samples_checked = 0;
    b_ncmpl         = 0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      // power-up values of the initialised block
      for (int i = 'h40; i <= 'h4a; i++) begin
        xfer(b[0], padr(7'(i), !b[0]), 1'b0, 16'h0, q, r);
        check({r, 16'h0, q}, {`MW_RESP_OKAY, 16'h0, init_exp(7'(i))});
      end
      // neighbouring registers must not alias under either spacing
      for (int k = 0; k < 6; k++) begin
        seed = lfsr(seed);
        d    = lfsr(seed);
        ix   = {1'b0, seed[5:1], 1'b0} | 7'h02;
        xfer(b[0], padr(ix, !b[0]), 1'b1, seed, q, r);
        xfer(b[0], padr(ix + 7'h1, !b[0]), 1'b1, d, q, r);
        xfer(b[0], padr(ix, !b[0]), 1'b0, 16'h0, q, r);
        check({r, 16'h0, q}, {`MW_RESP_OKAY, 16'h0, seed});
        xfer(b[0], padr(ix + 7'h1, !b[0]), 1'b0, 16'h0, q, r);
        check({r, 16'h0, q}, {`MW_RESP_OKAY, 16'h0, d});
      end
      xfer(b[0], 32'h0020_0000, 1'b0, 16'h0, q, r);
      check({r, 16'h0, q}, {`MW_RESP_DECERR, 32'h0});
      $display("test init and mapping done, side %0d", b);
    end
    // start bit from the control register
    xfer(1'b0, 32'h0, 1'b1, 16'h1, q, r);
    @(negedge ref_clk);
    check({33'h0, a_cs}, 34'h1);
    xfer(1'b0, 32'h0, 1'b1, 16'h0, q, r);
    @(negedge ref_clk);
    check({33'h0, a_cs}, 34'h0);
    // external start passed straight through
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      @(posedge ref_clk);
      conv_in <= seed[0];
      @(negedge ref_clk);
      check({33'h0, b_cs}, {33'h0, seed[0]});
    end
    // register start reached the primitive: eoc set, result stepped once
    repeat (30) @(posedge ref_clk);
    xfer(1'b0, {24'h0, `MW_OFS_STAT}, 1'b0, 16'h0, q, r);
    check({r, 16'h0, q}, {`MW_RESP_OKAY, 16'h0, 16'h1 << `MW_STAT_EOC_BIT});
    xfer(1'b0, padr(`MW_RESULT_IDX, 1'b1), 1'b0, 16'h0, q, r);
    check({r, 16'h0, q}, {`MW_RESP_OKAY, 16'h0, 16'h0001});
    $display("test conversion start done");
    close_out();
  end
endmodule // monitor_ahb_wrapper_config_test
`default_nettype wire
